/* src/ppc_top.sv */
// port pin configuration: pads, pulls, wake inputs, reset and mode pins
// Notes on behaviour
// R1: reset pin active low, driven on internal reset
// R2: mode pin captured at reset pin rising edge
// R3: every pin has selectable, individually enabled pull
// R4: ports A,B,D-H reset with pull-down enabled
// R5: AD,C,P,T,U,V reset with pulls disabled
// R6: port S resets with pull-up enabled
// R7: AD, S, T pins are wake interrupt inputs
// R8: port S pins individually open-drain
// R9: ports U, V per-pin slew enable
// R10: spi master-in pin: master input, slave output
// R11: spi master-out pin: master output, slave input
// R12: calibration pin drives clock or takes 1 Hz
// R13: software pulls or drives unbonded pins; the code masks writes to unbonded bits, which stay zero
// R14: all pin configuration returns to defaults on reset
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module ppc_top (
    input  wire logic                                             clk,
    input  wire logic                                             rst_b,
    input  wire logic [ppc_pkg::ADDR_W-1:0]                       reg_addr,
    input  wire logic [7:0]                                       reg_wdata,
    input  wire logic                                             reg_wr,
    input  wire logic                                             reg_rd,
    output logic      [7:0]                                       reg_rdata,
    input  wire logic [ppc_pkg::NUM_PORTS-1:0][ppc_pkg::PORT_W-1:0] gpio_pad_in,
    output ppc_pkg::ppc_pad_t [ppc_pkg::NUM_PORTS-1:0]            gpio_pad,
    output logic                                                  wake_req,
    input  wire logic                                             reset_pin_in,
    output logic                                                  reset_pin_out,
    output logic                                                  reset_pin_oe,
    input  wire logic                                             int_reset_req,
    output logic                                                  sys_reset_req,
    input  wire logic                                             mode_select_pin,
    output logic                                                  op_mode,
    input  wire logic                                             spi_master_mode,
    input  wire logic                                             spi_mosi_tx,
    input  wire logic                                             spi_miso_tx,
    input  wire logic                                             spi_master_in_pin_in,
    output logic                                                  spi_master_in_pin_out,
    output logic                                                  spi_master_in_pin_oe,
    input  wire logic                                             spi_master_out_pin_in,
    output logic                                                  spi_master_out_pin_out,
    output logic                                                  spi_master_out_pin_oe,
    output logic                                                  spi_miso_rx,
    output logic                                                  spi_mosi_rx,
    input  wire logic                                             rtc_cal_clk,
    input  wire logic                                             cal_pin_in,
    output logic                                                  calibration_clock_out,
    output logic                                                  cal_pin_oe,
    output logic                                                  cal_ref_in
);

    localparam int NP = ppc_pkg::NUM_PORTS;
    localparam int PW = ppc_pkg::PORT_W;

    ppc_pkg::ppc_cfg_t [NP-1:0] cfg;
    logic [NP-1:0][PW-1:0]      pin_s1_reg;
    logic [NP-1:0][PW-1:0]      pin_s2_reg;
    logic [NP-1:0][PW-1:0]      pin_prev_reg;
    logic [NP-1:0][PW-1:0]      wake_en_reg;
    logic [NP-1:0][PW-1:0]      wake_flag_reg;
    logic [NP-1:0][PW-1:0]      special_reg;
    logic [NP-1:0]              wake_any;
    logic                       rst_s1_reg;
    logic                       rst_s2_reg;
    logic                       rst_prev_reg;
    logic                       mode_s1_reg;
    logic                       mode_s2_reg;
    logic                       miso_s1_reg;
    logic                       mosi_s1_reg;
    logic                       cal_s1_reg;
    logic [7:0]                 ctrl_reg;
    logic [7:0]                 status_reg;
    logic [7:0]                 rd_next;
    logic                       soft_rst;
    logic                       rst_rise;
    logic                       port_wr;

    // a low level on the pin or an internal request resets the configuration
    assign soft_rst = ~rst_s2_reg | int_reset_req; // R1
    assign rst_rise = rst_s2_reg & ~rst_prev_reg;
    assign port_wr  = reg_wr & (reg_addr[ppc_pkg::ADDR_W-1:3] != ppc_pkg::GLOBAL_IDX);

    // basic per-port registers
    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            ppc_port_regs #(
                .PIN_MASK    (ppc_pkg::PIN_MASK[p]),
                .PULL_EN_DEF (ppc_pkg::PULL_EN_RST[p]),
                .PULL_UP_DEF (ppc_pkg::PULL_UP_RST[p])
            ) u_regs (
                .clk      (clk),
                .rst_b    (rst_b),
                .soft_rst (soft_rst),
                .wr_en    (port_wr && (reg_addr[ppc_pkg::ADDR_W-1:3] == 4'(p))),
                .field    (reg_addr[2:0]),
                .wdata    (reg_wdata),
                .cfg_reg  (cfg[p])
            );

            // wake enable and sticky wake flags, set beats write-one-to-clear
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    wake_en_reg[p]   <= 8'h00;
                    wake_flag_reg[p] <= 8'h00;
                end else if (soft_rst || !ppc_pkg::WAKE_PORTS[p]) begin
                    wake_en_reg[p]   <= 8'h00; // R14
                    wake_flag_reg[p] <= 8'h00;
                end else begin
                    if (ppc_pkg::field_hit(reg_addr, 4'(p), ppc_pkg::FLD_WAKE_EN) && reg_wr) begin
                        wake_en_reg[p] <= reg_wdata & ppc_pkg::PIN_MASK[p]; // R7
                    end
                    wake_flag_reg[p] <= (wake_flag_reg[p]
                        & ~((ppc_pkg::field_hit(reg_addr, 4'(p), ppc_pkg::FLD_WAKE_FLAG) && reg_wr)
                            ? reg_wdata : 8'h00))
                        | (wake_en_reg[p] & pin_prev_reg[p] & ~pin_s2_reg[p]); // R7
                end
            end

            // open-drain select on port S, slew enable on ports U and V
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    special_reg[p] <= 8'h00;
                end else if (soft_rst || !ppc_pkg::SPECIAL_PORTS[p]) begin
                    special_reg[p] <= 8'h00; // R14
                end else if (ppc_pkg::field_hit(reg_addr, 4'(p), ppc_pkg::FLD_SPECIAL) && reg_wr) begin
                    special_reg[p] <= reg_wdata & ppc_pkg::PIN_MASK[p]; // R8 R9
                end
            end

            // pad drive: open-drain pins never drive high, they float instead
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    gpio_pad[p] <= '0;
                end else begin
                    if (4'(p) == ppc_pkg::PORT_S) begin
                        gpio_pad[p].out  <= cfg[p].dout & ~special_reg[p]; // R8
                        gpio_pad[p].oe   <= cfg[p].dir & ~(special_reg[p] & cfg[p].dout); // R8
                        gpio_pad[p].slew <= 8'h00;
                    end else begin
                        gpio_pad[p].out  <= cfg[p].dout;
                        gpio_pad[p].oe   <= cfg[p].dir;
                        gpio_pad[p].slew <= special_reg[p]; // R9
                    end
                    gpio_pad[p].pull_en <= cfg[p].pull_en; // R3
                    gpio_pad[p].pull_up <= cfg[p].pull_up; // R3
                end
            end

            assign wake_any[p] = |(wake_flag_reg[p] & wake_en_reg[p]);
        end
    endgenerate

    // two-stage synchronisers for pad inputs, plus an edge history stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg   <= '0;
            pin_s2_reg   <= '0;
            pin_prev_reg <= '0;
        end else begin
            pin_s1_reg   <= gpio_pad_in;
            pin_s2_reg   <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
        end
    end

    // wake request leaves the block on a flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= |wake_any; // R7
        end
    end

    // reset pin: synchronised input, low drive while an internal reset runs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_reg    <= 1'b0;
            rst_s2_reg    <= 1'b0;
            rst_prev_reg  <= 1'b0;
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= 1'b0;
            sys_reset_req <= 1'b1;
        end else begin
            rst_s1_reg    <= reset_pin_in;
            rst_s2_reg    <= rst_s1_reg;
            rst_prev_reg  <= rst_s2_reg;
            reset_pin_out <= 1'b0;          // R1
            reset_pin_oe  <= int_reset_req; // R1
            sys_reset_req <= soft_rst;      // R1
        end
    end

    // mode select pin latched when the reset pin rises
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_s1_reg <= ppc_pkg::MODE_RST;
            mode_s2_reg <= ppc_pkg::MODE_RST;
            op_mode     <= ppc_pkg::MODE_RST;
        end else begin
            mode_s1_reg <= mode_select_pin;
            mode_s2_reg <= mode_s1_reg;
            if (rst_rise) begin
                op_mode <= mode_s2_reg; // R2
            end
        end
    end

    // reset cause status, sticky until cleared by writing ones
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= 8'h00;
        end else begin
            status_reg <= (status_reg & ~((ppc_pkg::field_hit(reg_addr, ppc_pkg::GLOBAL_IDX,
                                             ppc_pkg::G_STATUS) && reg_wr) ? reg_wdata : 8'h00))
                        | {6'h00, int_reset_req, ~rst_s2_reg & ~int_reset_req};
        end
    end

    // global control: calibration pin direction
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= 8'h00;
        end else if (soft_rst) begin
            ctrl_reg <= 8'h00; // R14
        end else if (ppc_pkg::field_hit(reg_addr, ppc_pkg::GLOBAL_IDX, ppc_pkg::G_CTRL) && reg_wr) begin
            ctrl_reg <= {7'h00, reg_wdata[ppc_pkg::CTRL_CAL_OUT_BIT]};
        end
    end

    // spi data pins follow master or slave role
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spi_master_in_pin_out  <= 1'b0;
            spi_master_in_pin_oe   <= 1'b0;
            spi_master_out_pin_out <= 1'b0;
            spi_master_out_pin_oe  <= 1'b0;
            miso_s1_reg            <= 1'b0;
            mosi_s1_reg            <= 1'b0;
            spi_miso_rx            <= 1'b0;
            spi_mosi_rx            <= 1'b0;
        end else begin
            spi_master_in_pin_out  <= spi_miso_tx;
            spi_master_in_pin_oe   <= ~spi_master_mode; // R10
            spi_master_out_pin_out <= spi_mosi_tx;
            spi_master_out_pin_oe  <= spi_master_mode;  // R11
            miso_s1_reg            <= spi_master_in_pin_in;
            mosi_s1_reg            <= spi_master_out_pin_in;
            spi_miso_rx            <= miso_s1_reg;
            spi_mosi_rx            <= mosi_s1_reg;
        end
    end

    // calibration pin: clock out, or synchronised 1 Hz reference in
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            calibration_clock_out <= 1'b0;
            cal_pin_oe            <= 1'b0;
            cal_s1_reg            <= 1'b0;
            cal_ref_in            <= 1'b0;
        end else begin
            calibration_clock_out <= rtc_cal_clk;                          // R12
            cal_pin_oe            <= ctrl_reg[ppc_pkg::CTRL_CAL_OUT_BIT];  // R12
            cal_s1_reg            <= cal_pin_in;
            cal_ref_in            <= cal_s1_reg;                           // R12
        end
    end

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_next = 8'h00;
        if (reg_addr[ppc_pkg::ADDR_W-1:3] == ppc_pkg::GLOBAL_IDX) begin
            unique case (reg_addr[2:0])
                ppc_pkg::G_MODE:   rd_next = {7'h00, op_mode};
                ppc_pkg::G_CTRL:   rd_next = ctrl_reg;
                ppc_pkg::G_STATUS: rd_next = status_reg;
                default:           rd_next = 8'h00;
            endcase
        end else if (reg_addr[ppc_pkg::ADDR_W-1:3] < 4'(NP)) begin
            unique case (reg_addr[2:0])
                ppc_pkg::FLD_DOUT:      rd_next = cfg[reg_addr[6:3]].dout;
                ppc_pkg::FLD_DIR:       rd_next = cfg[reg_addr[6:3]].dir;
                ppc_pkg::FLD_PULL_EN:   rd_next = cfg[reg_addr[6:3]].pull_en;
                ppc_pkg::FLD_PULL_UP:   rd_next = cfg[reg_addr[6:3]].pull_up;
                ppc_pkg::FLD_PIN_IN:    rd_next = pin_s2_reg[reg_addr[6:3]]
                                                  & ppc_pkg::PIN_MASK[reg_addr[6:3]];
                ppc_pkg::FLD_WAKE_EN:   rd_next = wake_en_reg[reg_addr[6:3]];
                ppc_pkg::FLD_WAKE_FLAG: rd_next = wake_flag_reg[reg_addr[6:3]];
                ppc_pkg::FLD_SPECIAL:   rd_next = special_reg[reg_addr[6:3]];
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_next : 8'h00;
        end
    end

    a_reset_pin_drive: assert property (@(posedge clk) disable iff (!rst_b) // R1
        int_reset_req |=> (reset_pin_oe && !reset_pin_out && sys_reset_req))
        else $error("reset pin not driven low on internal reset");

    a_mode_latch_edge: assert property (@(posedge clk) disable iff (!rst_b) // R2
        (!rst_s2_reg ##1 rst_s2_reg) |=> (op_mode == $past(mode_s2_reg)))
        else $error("mode bit not captured at reset pin rise");

    a_pull_follows_cfg: assert property (@(posedge clk) disable iff (!rst_b) // R3
        1'b1 |=> (gpio_pad[0].pull_en == $past(cfg[0].pull_en)
                  && gpio_pad[0].pull_up == $past(cfg[0].pull_up)))
        else $error("pull pad controls do not follow configuration");

    a_pull_down_default: assert property (@(posedge clk) disable iff (!rst_b) // R4
        soft_rst |=> (cfg[ppc_pkg::PORT_A].pull_en == 8'hff && cfg[ppc_pkg::PORT_B].pull_en == 8'h0f
                      && cfg[ppc_pkg::PORT_A].pull_up == 8'h00))
        else $error("pull-down default missing after reset");

    a_pull_off_default: assert property (@(posedge clk) disable iff (!rst_b) // R5
        soft_rst |=> (cfg[ppc_pkg::PORT_C].pull_en == 8'h00 && cfg[ppc_pkg::PORT_T].pull_en == 8'h00))
        else $error("pull devices not disabled after reset");

    a_pull_up_default: assert property (@(posedge clk) disable iff (!rst_b) // R6
        soft_rst |=> (cfg[ppc_pkg::PORT_S].pull_en == 8'hff && cfg[ppc_pkg::PORT_S].pull_up == 8'hff))
        else $error("port S pull-up default missing after reset");

    a_wake_flag_set: assert property (@(posedge clk) disable iff (!rst_b) // R7
        (!soft_rst && (wake_en_reg[ppc_pkg::PORT_S] & pin_prev_reg[ppc_pkg::PORT_S]
                       & ~pin_s2_reg[ppc_pkg::PORT_S]) != 8'h00)
        |=> ##1 wake_req)
        else $error("wake edge did not raise wake request");

    a_open_drain_low: assert property (@(posedge clk) disable iff (!rst_b) // R8
        1'b1 |=> ((gpio_pad[ppc_pkg::PORT_S].out & $past(special_reg[ppc_pkg::PORT_S])) == 8'h00))
        else $error("open-drain pin driven high");

    a_slew_follow: assert property (@(posedge clk) disable iff (!rst_b) // R9
        1'b1 |=> (gpio_pad[ppc_pkg::PORT_U].slew == $past(special_reg[ppc_pkg::PORT_U])))
        else $error("slew enable does not follow its register");

    a_spi_pin_dir: assert property (@(posedge clk) disable iff (!rst_b) // R10 R11
        $changed(spi_master_mode) |=> (spi_master_in_pin_oe != spi_master_out_pin_oe)
                                      && (spi_master_out_pin_oe == $past(spi_master_mode)))
        else $error("spi data pin direction wrong for role");

    a_cal_pin_dir: assert property (@(posedge clk) disable iff (!rst_b) // R12
        (ctrl_reg[ppc_pkg::CTRL_CAL_OUT_BIT] && !soft_rst) [*2] |-> cal_pin_oe)
        else $error("calibration pin not driving in output mode");

endmodule : ppc_top

/* src/ppc_pkg.sv */
// constants, field layouts and carrier types for the port pin configuration block
package ppc_pkg;

    // geometry
    localparam int NUM_PORTS = 14;
    localparam int PORT_W    = 8;
    localparam int ADDR_W    = 7;

    // port index, upper four address bits
    localparam logic [3:0] PORT_AD    = 4'h0;
    localparam logic [3:0] PORT_A     = 4'h1;
    localparam logic [3:0] PORT_B     = 4'h2;
    localparam logic [3:0] PORT_C     = 4'h3;
    localparam logic [3:0] PORT_D     = 4'h4;
    localparam logic [3:0] PORT_E     = 4'h5;
    localparam logic [3:0] PORT_F     = 4'h6;
    localparam logic [3:0] PORT_G     = 4'h7;
    localparam logic [3:0] PORT_H     = 4'h8;
    localparam logic [3:0] PORT_P     = 4'h9;
    localparam logic [3:0] PORT_S     = 4'ha;
    localparam logic [3:0] PORT_T     = 4'hb;
    localparam logic [3:0] PORT_U     = 4'hc;
    localparam logic [3:0] PORT_V     = 4'hd;
    localparam logic [3:0] GLOBAL_IDX = 4'hf;

    // per-port register field, lower three address bits
    localparam logic [2:0] FLD_DOUT      = 3'h0;
    localparam logic [2:0] FLD_DIR       = 3'h1;
    localparam logic [2:0] FLD_PULL_EN   = 3'h2;
    localparam logic [2:0] FLD_PULL_UP   = 3'h3;
    localparam logic [2:0] FLD_PIN_IN    = 3'h4;
    localparam logic [2:0] FLD_WAKE_EN   = 3'h5;
    localparam logic [2:0] FLD_WAKE_FLAG = 3'h6;
    localparam logic [2:0] FLD_SPECIAL   = 3'h7;

    // global registers
    localparam logic [2:0] G_MODE   = 3'h0;
    localparam logic [2:0] G_CTRL   = 3'h1;
    localparam logic [2:0] G_STATUS = 3'h2;
    localparam int         CTRL_CAL_OUT_BIT  = 0;
    localparam int         STAT_PIN_RST_BIT  = 0;
    localparam int         STAT_INT_RST_BIT  = 1;

    // bonded pins of each port, index 13 down to 0
    localparam logic [NUM_PORTS-1:0][PORT_W-1:0] PIN_MASK = {
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};

    // reset defaults and capability masks, one bit per port, then the single-bit mode reset value
    localparam logic [NUM_PORTS-1:0] PULL_EN_RST   = 14'h05f6;
    localparam logic [NUM_PORTS-1:0] PULL_UP_RST   = 14'h0400;
    localparam logic [NUM_PORTS-1:0] WAKE_PORTS    = 14'h0c01;
    localparam logic [NUM_PORTS-1:0] SPECIAL_PORTS = 14'h3400;
    localparam logic                 MODE_RST      = 1'b1;

    typedef struct packed {
        logic [PORT_W-1:0] dout;
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] pull_en;
        logic [PORT_W-1:0] pull_up;
    } ppc_cfg_t;

    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
        logic [PORT_W-1:0] pull_en;
        logic [PORT_W-1:0] pull_up;
        logic [PORT_W-1:0] slew;
    } ppc_pad_t;

    // true when a register address selects the given block and field
    function automatic logic field_hit(input logic [ADDR_W-1:0] addr,
                                       input logic [3:0]        idx,
                                       input logic [2:0]        fld);
        field_hit = (addr[ADDR_W-1:3] == idx) && (addr[2:0] == fld);
    endfunction : field_hit

endpackage : ppc_pkg

/* src/ppc_port_regs.sv */
// basic configuration registers of one general-purpose port
`timescale 1ns/1ps
module ppc_port_regs #(
    parameter logic [7:0] PIN_MASK    = 8'hff,
    parameter logic       PULL_EN_DEF = 1'b0,
    parameter logic       PULL_UP_DEF = 1'b0
) (
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic            soft_rst,
    input  wire logic            wr_en,
    input  wire logic [2:0]      field,
    input  wire logic [7:0]      wdata,
    output ppc_pkg::ppc_cfg_t    cfg_reg
);

    localparam logic [7:0] PULL_EN_VAL = PULL_EN_DEF ? PIN_MASK : 8'h00;
    localparam logic [7:0] PULL_UP_VAL = PULL_UP_DEF ? PIN_MASK : 8'h00;

    // unbonded bits stay zero; every reset brings the defaults back
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg.dout    <= 8'h00;
            cfg_reg.dir     <= 8'h00;
            cfg_reg.pull_en <= PULL_EN_VAL; // R4 R5
            cfg_reg.pull_up <= PULL_UP_VAL; // R6
        end else if (soft_rst) begin
            cfg_reg.dout    <= 8'h00;
            cfg_reg.dir     <= 8'h00;
            cfg_reg.pull_en <= PULL_EN_VAL; // R14
            cfg_reg.pull_up <= PULL_UP_VAL; // R14
        end else if (wr_en) begin
            unique case (field)
                ppc_pkg::FLD_DOUT:    cfg_reg.dout    <= wdata & PIN_MASK;
                ppc_pkg::FLD_DIR:     cfg_reg.dir     <= wdata & PIN_MASK;
                ppc_pkg::FLD_PULL_EN: cfg_reg.pull_en <= wdata & PIN_MASK; // R3
                ppc_pkg::FLD_PULL_UP: cfg_reg.pull_up <= wdata & PIN_MASK; // R3
                default: ;
            endcase
        end
    end

endmodule : ppc_port_regs

/* verif/ppc_board.sv */
// board model: pad pins settle from driver, pull and forced lows
`timescale 1ns/1ps
module ppc_board (
    input  wire ppc_pkg::ppc_pad_t [13:0] pad,
    input  wire logic [13:0][7:0]         pull_low,
    output logic [13:0][7:0]              pad_in
);
    // driven level, else the pull, else the inverse of the last drive
    always_comb for (int p = 0; p < 14; p++) pad_in[p] = ~pull_low[p] & ((pad[p].oe & pad[p].out) | (~pad[p].oe &
        ((pad[p].pull_en & pad[p].pull_up) | (~pad[p].pull_en & ~pad[p].out))));
endmodule : ppc_board

/* verif/test_ppc_top.sv */
// bench for the port pin configuration block
`timescale 1ns/1ps
module test_ppc_top;
    logic                     clk, rst_b, reg_wr, reg_rd, int_reset_req, mode_select_pin, spi_master_mode, ext_b;
    logic                     wake_req, op_mode, cal_pin_oe, rst_pin, rst_oe, mi_oe, mo_oe, mi, mo, cal;
    logic                     rst_out, sys_rst, mi_rx, mo_rx, cal_rx, rtc;
    logic [6:0]               reg_addr;
    logic [7:0]               reg_wdata, reg_rdata, d;
    logic [13:0][7:0]         pad_in, pull_low;
    ppc_pkg::ppc_pad_t [13:0] pad;
    int                       mismatches = 0, n_compared = 0, p;
    localparam logic [14:0] SETUP [5] = '{{7'h51, 8'hff}, {7'h57, 8'hff}, {7'h50, 8'h0f}, {7'h67, 8'ha5}, {7'h79, 8'h01}};
    ppc_top ppc_top_i (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .gpio_pad_in(pad_in),
        .gpio_pad(pad), .wake_req, .reset_pin_in(rst_pin), .reset_pin_out(rst_out), .reset_pin_oe(rst_oe),
        .int_reset_req, .sys_reset_req(sys_rst), .mode_select_pin, .op_mode, .spi_master_mode, .spi_mosi_tx(1'b0),
        .spi_miso_tx(1'b1), .spi_master_in_pin_in(mi), .spi_master_in_pin_out(mi), .spi_master_in_pin_oe(mi_oe),
        .spi_miso_rx(mi_rx), .spi_master_out_pin_in(mo), .spi_master_out_pin_out(mo), .spi_master_out_pin_oe(mo_oe),
        .spi_mosi_rx(mo_rx), .rtc_cal_clk(rtc), .cal_pin_in(cal), .calibration_clock_out(cal), .cal_pin_oe,
        .cal_ref_in(cal_rx));
    ppc_board ppc_board_i (.pad, .pull_low, .pad_in);
    assign rst_pin = ext_b & ~rst_oe; // pulled-up line, low while either side drives it
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(logic [7:0] g, logic [7:0] e);
        n_compared++;
        mismatches += int'(g !== e);
        if (g !== e) $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    endtask : chk
    task automatic wr(logic [6:0] a, logic [7:0] v);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [6:0] a, logic [7:0] e);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) reg_rd <= 1'b0;
        @(negedge clk) chk(reg_rdata, e);
    endtask : rd
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        finish_test();
    end
    // reset, then the tests
    initial begin
        {rst_b, reg_wr, reg_rd, int_reset_req, spi_master_mode, reg_addr, reg_wdata, pull_low} = '0;
        {ext_b, mode_select_pin, rtc} = 3'b000;
        void'($urandom(32'h580a));
        repeat (20) @(posedge clk);
        {rst_b, ext_b, mode_select_pin} <= 3'h7;
        repeat (4) @(posedge clk);
        wr(7'h55, 8'h03);
        pull_low[10] <= 8'h01;
        rtc <= 1'b1;
        repeat (20) begin
            p = $urandom_range(13);
            d = 8'($urandom);
            wr({p[3:0], 3'h2}, d);
            rd({p[3:0], 3'h2}, d & ppc_pkg::PIN_MASK[p]);
        end
        chk(8'(wake_req), 8'h01);
        $display("pull and wake done");
        foreach (SETUP[i]) wr(SETUP[i][14:8], SETUP[i][7:0]);
        repeat (3) @(posedge clk);
        chk(pad[10].oe, 8'hf0);
        chk(pad[12].slew, 8'ha5);
        chk(8'(cal_pin_oe), 8'h01);
        chk(8'({mi_rx, mo_rx, cal, cal_rx}), 8'h0b);
        rd(7'h70, 8'h00);
        $display("special done");
        for (int m = 0; m < 2; m++) begin
            {spi_master_mode, mode_select_pin, int_reset_req, ext_b} <= {m[0], m[0], 1'b1, m[0]};
            repeat (3) @(posedge clk);
            chk(8'({rst_oe, rst_out, sys_rst, mi_oe, mo_oe}), 8'({2'b10, 1'b1, ~m[0], m[0]}));
            {int_reset_req, ext_b} <= 2'b01;
            repeat (12) @(posedge clk);
            chk(8'({op_mode, sys_rst}), 8'({m[0], 1'b0}));
            for (int q = 0; q < 14; q++) begin
                chk(pad[q].pull_en & ppc_pkg::PIN_MASK[q], (q inside {0, 3, 9, 11, 12, 13}) ? 8'h00 : ppc_pkg::PIN_MASK[q]);
                chk(pad[q].pull_up, (q == 10) ? 8'hff : 8'h00);
            end
        end
        rd(7'h7a, 8'h03);
        wr(7'h7a, 8'h03);
        rd(7'h7a, 8'h00);
        $display("reset done");
        finish_test();
    end
endmodule : test_ppc_top
